// ### rtl/drm_top.v
// reference monitor for four references with an axi4-lite register slave
//
// The register offsets and register access over AXI4-Lite were decided locally.
`include "drm_defines.vh"
`default_nettype none
// Operation
// RULE1 - limits counted in 10 ns ticks
// RULE2 - per reference programmable lower and upper period
// RULE3 - single period check flags loss early
// RULE4 - 8 kHz single period limit defaults
// RULE5 - 1.544 and 2.048 MHz single limits
// RULE6 - detect frequency offset over many periods
// RULE7 - programmable window, ten seconds by default
// RULE8 - fail beyond far, pass within near
// RULE9 - two agreeing measurements before deciding
// RULE10 - window count from two 16-bit halves
// RULE11 - shared multi limits, split low and high
// RULE12 - limit enable clear selects built-in defaults
// RULE13 - reset values suit 8 kHz references
// RULE14 - far upper, near upper, nominal defaults
// RULE15 - near lower and far lower defaults
// RULE16 - independent monitor per reference
// RULE17 - readable status and ignoring mask
// RULE18 - period counted between rising edges
// RULE19 - fail held steady, synchronous output
module drm_top (
   input wire core_clk_i,
   input wire rst_i,
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [3:0] ref_clk_i,
   output reg [3:0] ref_fail_o,
   output reg irq_o
);
   localparam [31:0] TICK_INC_W = `DRM_TICK_INC;
   localparam [31:0] TICK_MOD_W = `DRM_TICK_MOD;
   localparam [2:0] TICK_INC = TICK_INC_W[2:0];
   localparam [2:0] TICK_MOD = TICK_MOD_W[2:0];
   localparam [31:0] RST_WIN = `DRM_RST_WIN;
   localparam [31:0] RST_NEAR_UP = `DRM_RST_NEAR_UP;
   localparam [31:0] RST_FAR_UP = `DRM_RST_FAR_UP;
   localparam [31:0] RST_NEAR_LO = `DRM_RST_NEAR_LO;
   localparam [31:0] RST_FAR_LO = `DRM_RST_FAR_LO;

   // ==========================================
   // registers
   reg [15:0] ctrl_q;
   reg [7:0] mask_q;
   reg [7:0] irq_stat_q;
   reg [7:0] irq_mask_q;
   reg [15:0] sp_lo_q [0:3];
   reg [15:0] sp_up_q [0:3];
   reg [15:0] win_lo_q [0:3];
   reg [15:0] win_hi_q [0:3];
   reg [15:0] mlim_q [0:7];
   reg [2:0] acc_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg aw_have_q;
   reg w_have_q;
   integer i;

   wire [3:0] ref_s;
   wire [3:0] sp_fail;
   wire [3:0] mp_fail;
   wire [3:0] sp_evt;
   wire [3:0] mp_evt;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] d;
      input [3:0] s;
      begin
         merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   // ==========================================
   // 100 MHz tick from the 250 MHz clock: two ticks per five cycles
   wire tick_w = (acc_q >= TICK_MOD - TICK_INC); // RULE1
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) acc_q <= 3'd0;
      else if (tick_w) acc_q <= acc_q + TICK_INC - TICK_MOD;
      else acc_q <= acc_q + TICK_INC;
   end

   drm_sync #(.W(4)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i(ref_clk_i),
      .q_o(ref_s)
   );

   // ==========================================
   // four independent monitors
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_mon
         drm_chan u_chan ( // RULE16
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .tick_i(tick_w),
            .ref_i(ref_s[g]),
            .monitor_limit_enable_i(ctrl_q[`DRM_MONITOR_LIMIT_ENABLE_BIT]),
            .sp_upper_i(sp_up_q[g]),
            .sp_lower_i(sp_lo_q[g]),
            .win_i({win_hi_q[g], win_lo_q[g]}), // RULE10
            .near_up_i({mlim_q[1], mlim_q[0]}), // RULE11
            .far_up_i({mlim_q[3], mlim_q[2]}),
            .near_lo_i({mlim_q[5], mlim_q[4]}),
            .far_lo_i({mlim_q[7], mlim_q[6]}),
            .sp_fail_o(sp_fail[g]),
            .mp_fail_o(mp_fail[g]),
            .sp_evt_o(sp_evt[g]),
            .mp_evt_o(mp_evt[g])
         );
      end
   endgenerate

   // ==========================================
   // write decode
   wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid_o;
   wire [3:0] wpage = aw_addr_q[7:4];
   wire [1:0] widx = aw_addr_q[3:2];
   reg wr_ok;
   always @* begin
      wr_ok = 1'b1;
      if (aw_addr_q[1:0] != 2'b00) wr_ok = 1'b0;
      else if (aw_addr_q == `DRM_ADDR_CTRL) wr_ok = 1'b1;
      else if (aw_addr_q == `DRM_ADDR_STATUS) wr_ok = 1'b1;
      else if (aw_addr_q == `DRM_ADDR_MASK) wr_ok = 1'b1;
      else if (aw_addr_q == `DRM_ADDR_IRQ_STAT) wr_ok = 1'b1;
      else if (aw_addr_q == `DRM_ADDR_IRQ_MASK) wr_ok = 1'b1;
      else if (wpage >= `DRM_PAGE_SP_LOWER && wpage <= `DRM_PAGE_MLIM_B) wr_ok = 1'b1;
      else wr_ok = 1'b0;
   end

   // ==========================================
   // read decode
   wire rd_go = s_axi_arvalid_i & s_axi_arready_o;
   wire [3:0] rpage = s_axi_araddr_i[7:4];
   wire [1:0] ridx = s_axi_araddr_i[3:2];
   reg [31:0] rd_data;
   reg rd_ok;
   always @* begin
      rd_data = 32'h00000000;
      rd_ok = 1'b1;
      if (s_axi_araddr_i[1:0] != 2'b00) rd_ok = 1'b0;
      else if (s_axi_araddr_i == `DRM_ADDR_CTRL) rd_data = {16'h0000, ctrl_q};
      else if (s_axi_araddr_i == `DRM_ADDR_STATUS) rd_data = {24'h000000, mp_fail, sp_fail}; // RULE17
      else if (s_axi_araddr_i == `DRM_ADDR_MASK) rd_data = {24'h000000, mask_q};
      else if (s_axi_araddr_i == `DRM_ADDR_IRQ_STAT) rd_data = {24'h000000, irq_stat_q};
      else if (s_axi_araddr_i == `DRM_ADDR_IRQ_MASK) rd_data = {24'h000000, irq_mask_q};
      else if (rpage == `DRM_PAGE_SP_LOWER) rd_data = {16'h0000, sp_lo_q[ridx]};
      else if (rpage == `DRM_PAGE_SP_UPPER) rd_data = {16'h0000, sp_up_q[ridx]};
      else if (rpage == `DRM_PAGE_WIN_LOW) rd_data = {16'h0000, win_lo_q[ridx]};
      else if (rpage == `DRM_PAGE_WIN_HIGH) rd_data = {16'h0000, win_hi_q[ridx]};
      else if (rpage == `DRM_PAGE_MLIM_A) rd_data = {16'h0000, mlim_q[{1'b0, ridx}]};
      else if (rpage == `DRM_PAGE_MLIM_B) rd_data = {16'h0000, mlim_q[{1'b1, ridx}]};
      else rd_ok = 1'b0;
   end

   // ==========================================
   // interrupt status: set wins over read clear
   wire [7:0] evt_w = {mp_evt, sp_evt};
   wire irq_rd = rd_go && (s_axi_araddr_i == `DRM_ADDR_IRQ_STAT);
   wire [7:0] irq_stat_d = (irq_rd ? 8'h00 : irq_stat_q) | evt_w;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_q <= 8'h00;
         irq_o <= 1'b0;
         ref_fail_o <= 4'hf;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_o <= |(irq_stat_d & irq_mask_q);
         ref_fail_o <= (sp_fail & ~mask_q[3:0]) | (mp_fail & ~mask_q[7:4]); // RULE17 RULE19
      end
   end

   // ==========================================
   // axi4-lite write channel and register writes
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `DRM_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         ctrl_q <= 16'h0000;
         mask_q <= 8'h00;
         irq_mask_q <= 8'h00;
         for (i = 0; i < 4; i = i + 1) begin
            sp_lo_q[i] <= `DRM_RST_SP_LOWER; // RULE4
            sp_up_q[i] <= `DRM_RST_SP_UPPER; // RULE4
            win_lo_q[i] <= RST_WIN[15:0]; // RULE13
            win_hi_q[i] <= RST_WIN[31:16];
         end
         mlim_q[0] <= RST_NEAR_UP[15:0]; // RULE14
         mlim_q[1] <= RST_NEAR_UP[31:16];
         mlim_q[2] <= RST_FAR_UP[15:0]; // RULE14
         mlim_q[3] <= RST_FAR_UP[31:16];
         mlim_q[4] <= RST_NEAR_LO[15:0]; // RULE15
         mlim_q[5] <= RST_NEAR_LO[31:16];
         mlim_q[6] <= RST_FAR_LO[15:0]; // RULE15
         mlim_q[7] <= RST_FAR_LO[31:16];
      end else begin
         if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end else if (!aw_have_q && !s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
         end
         if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end else if (!w_have_q && !s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? `DRM_RESP_OKAY : `DRM_RESP_SLVERR;
            if (!wr_ok) ctrl_q <= ctrl_q;
            else if (aw_addr_q == `DRM_ADDR_CTRL) ctrl_q <= merge16(ctrl_q, w_data_q, w_strb_q);
            else if (aw_addr_q == `DRM_ADDR_MASK) begin
               if (w_strb_q[0]) mask_q <= w_data_q[7:0];
            end
            else if (aw_addr_q == `DRM_ADDR_IRQ_MASK) begin
               if (w_strb_q[0]) irq_mask_q <= w_data_q[7:0];
            end
            else if (wpage == `DRM_PAGE_SP_LOWER) sp_lo_q[widx] <= merge16(sp_lo_q[widx], w_data_q, w_strb_q); // RULE2
            else if (wpage == `DRM_PAGE_SP_UPPER) sp_up_q[widx] <= merge16(sp_up_q[widx], w_data_q, w_strb_q);
            else if (wpage == `DRM_PAGE_WIN_LOW) win_lo_q[widx] <= merge16(win_lo_q[widx], w_data_q, w_strb_q);
            else if (wpage == `DRM_PAGE_WIN_HIGH) win_hi_q[widx] <= merge16(win_hi_q[widx], w_data_q, w_strb_q);
            else if (wpage == `DRM_PAGE_MLIM_A)
               mlim_q[{1'b0, widx}] <= merge16(mlim_q[{1'b0, widx}], w_data_q, w_strb_q); // RULE11
            else if (wpage == `DRM_PAGE_MLIM_B)
               mlim_q[{1'b1, widx}] <= merge16(mlim_q[{1'b1, widx}], w_data_q, w_strb_q);
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // ==========================================
   // axi4-lite read channel
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= `DRM_RESP_OKAY;
      end else begin
         if (rd_go) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_data;
            s_axi_rresp_o <= rd_ok ? `DRM_RESP_OKAY : `DRM_RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/drm_defines.vh
// constants of the reference monitor: offsets, reset values, default tables
`ifndef DRM_DEFINES_VH
`define DRM_DEFINES_VH
// ==========================================
// clocks
`define DRM_CLK_MHZ 250
`define DRM_MEAS_MHZ 100
`define DRM_TICK_GCD 50
`define DRM_TICK_INC (`DRM_MEAS_MHZ / `DRM_TICK_GCD)
`define DRM_TICK_MOD (`DRM_CLK_MHZ / `DRM_TICK_GCD)
// ==========================================
// register byte offsets
`define DRM_ADDR_CTRL 8'h00
`define DRM_ADDR_STATUS 8'h04
`define DRM_ADDR_MASK 8'h08
`define DRM_ADDR_IRQ_STAT 8'h0c
`define DRM_ADDR_IRQ_MASK 8'h10
`define DRM_PAGE_SP_LOWER 4'h2
`define DRM_PAGE_SP_UPPER 4'h3
`define DRM_PAGE_WIN_LOW 4'h4
`define DRM_PAGE_WIN_HIGH 4'h5
`define DRM_PAGE_MLIM_A 4'h6
`define DRM_PAGE_MLIM_B 4'h7
`define DRM_MONITOR_LIMIT_ENABLE_BIT 2
`define DRM_RESP_OKAY 2'b00
`define DRM_RESP_SLVERR 2'b10
// ==========================================
// reset values
`define DRM_RST_SP_UPPER 16'h2e4a
`define DRM_RST_SP_LOWER 16'h335c
`define DRM_RST_WIN 32'h00013880
`define DRM_RST_FAR_UP 32'h3b9a9de8
`define DRM_RST_NEAR_UP 32'h3b9aa346
`define DRM_RST_NOMINAL 32'h3b9ac9ff
`define DRM_RST_NEAR_LO 32'h3b9af0b8
`define DRM_RST_FAR_LO 32'h3b9af616
// ==========================================
// frequency classes and period thresholds (10 ns units)
`define DRM_CLS_8K 3'd0
`define DRM_CLS_1M544 3'd1
`define DRM_CLS_2M048 3'd2
`define DRM_CLS_4M096 3'd3
`define DRM_CLS_8M192 3'd4
`define DRM_CLS_16M384 3'd5
`define DRM_CLS_19M44 3'd6
`define DRM_TH_8K 16'd1000
`define DRM_TH_1M544 16'd57
`define DRM_TH_2M048 16'd37
`define DRM_TH_4M096 16'd18
`define DRM_TH_8M192 16'd9
`define DRM_TH_16M384 16'd6
// ==========================================
// built-in single period limits per class
`define DRM_SPU_1M544 16'h002b
`define DRM_SPL_1M544 16'h0055
`define DRM_SPU_2M048 16'h0025
`define DRM_SPL_2M048 16'h003b
`define DRM_SPU_4M096 16'h0011
`define DRM_SPL_4M096 16'h001e
`define DRM_SPU_8M192 16'h0007
`define DRM_SPL_8M192 16'h000f
`define DRM_SPU_16M384 16'h0002
`define DRM_SPL_16M384 16'h0008
`define DRM_SPU_19M44 16'h0002
`define DRM_SPL_19M44 16'h0007
// built-in window lengths (cycles in ten seconds)
`define DRM_WIN_1M544 32'd15440000
`define DRM_WIN_2M048 32'd20480000
`define DRM_WIN_4M096 32'd40960000
`define DRM_WIN_8M192 32'd81920000
`define DRM_WIN_16M384 32'd163840000
`define DRM_WIN_19M44 32'd194400000
`endif

// ### rtl/drm_sync.v
// two flip-flop synchroniser for the reference clock pins
`default_nettype none
module drm_sync #(
   parameter W = 4
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta_q;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### rtl/drm_chan.v
// one reference monitor: single period check and multi period check with hysteresis
`include "drm_defines.vh"
`default_nettype none
module drm_chan (
   input wire core_clk_i,
   input wire rst_i,
   input wire tick_i,
   input wire ref_i,
   input wire monitor_limit_enable_i,
   input wire [15:0] sp_upper_i,
   input wire [15:0] sp_lower_i,
   input wire [31:0] win_i,
   input wire [31:0] near_up_i,
   input wire [31:0] far_up_i,
   input wire [31:0] near_lo_i,
   input wire [31:0] far_lo_i,
   output reg sp_fail_o,
   output reg mp_fail_o,
   output reg sp_evt_o,
   output reg mp_evt_o
);
   reg ref_prev_q;
   reg seen_q;
   reg sync_q;
   reg [15:0] per_q;
   reg [2:0] cls_q;
   reg [31:0] cyc_q;
   reg [31:0] dur_q;
   reg have_q;
   reg cand_q;
   reg [15:0] up_w;
   reg [15:0] lo_w;
   reg [31:0] win_w;

   function [2:0] classify;
      input [15:0] p;
      begin
         if (p >= `DRM_TH_8K) classify = `DRM_CLS_8K;
         else if (p >= `DRM_TH_1M544) classify = `DRM_CLS_1M544;
         else if (p >= `DRM_TH_2M048) classify = `DRM_CLS_2M048;
         else if (p >= `DRM_TH_4M096) classify = `DRM_CLS_4M096;
         else if (p >= `DRM_TH_8M192) classify = `DRM_CLS_8M192;
         else if (p >= `DRM_TH_16M384) classify = `DRM_CLS_16M384;
         else classify = `DRM_CLS_19M44;
      end
   endfunction

   // ==========================================
   // active limits: programmed or built-in per detected class
   always @* begin
      up_w = `DRM_RST_SP_UPPER;
      lo_w = `DRM_RST_SP_LOWER;
      win_w = `DRM_RST_WIN;
      case (cls_q)
         `DRM_CLS_1M544: begin up_w = `DRM_SPU_1M544; lo_w = `DRM_SPL_1M544; win_w = `DRM_WIN_1M544; end // RULE5
         `DRM_CLS_2M048: begin up_w = `DRM_SPU_2M048; lo_w = `DRM_SPL_2M048; win_w = `DRM_WIN_2M048; end // RULE5
         `DRM_CLS_4M096: begin up_w = `DRM_SPU_4M096; lo_w = `DRM_SPL_4M096; win_w = `DRM_WIN_4M096; end
         `DRM_CLS_8M192: begin up_w = `DRM_SPU_8M192; lo_w = `DRM_SPL_8M192; win_w = `DRM_WIN_8M192; end
         `DRM_CLS_16M384: begin up_w = `DRM_SPU_16M384; lo_w = `DRM_SPL_16M384; win_w = `DRM_WIN_16M384; end
         `DRM_CLS_19M44: begin up_w = `DRM_SPU_19M44; lo_w = `DRM_SPL_19M44; win_w = `DRM_WIN_19M44; end
         default: begin up_w = `DRM_RST_SP_UPPER; lo_w = `DRM_RST_SP_LOWER; win_w = `DRM_RST_WIN; end
      endcase
      if (monitor_limit_enable_i) begin // RULE12
         up_w = sp_upper_i;
         lo_w = sp_lower_i;
         win_w = win_i;
      end
   end

   wire [31:0] fu_w = monitor_limit_enable_i ? far_up_i : `DRM_RST_FAR_UP; // RULE12
   wire [31:0] nu_w = monitor_limit_enable_i ? near_up_i : `DRM_RST_NEAR_UP;
   wire [31:0] nl_w = monitor_limit_enable_i ? near_lo_i : `DRM_RST_NEAR_LO;
   wire [31:0] fl_w = monitor_limit_enable_i ? far_lo_i : `DRM_RST_FAR_LO;

   wire edge_w = ref_i & ~ref_prev_q;
   // period in 10 ns ticks, saturating
   wire [15:0] per_w = (per_q == 16'hffff) ? per_q : per_q + {15'd0, tick_i}; // RULE18 RULE1
   wire sp_bad_w = (per_w < up_w) || (per_w > lo_w); // RULE2
   wire [31:0] dur_w = (dur_q == 32'hffffffff) ? dur_q : dur_q + {31'd0, tick_i}; // RULE6
   wire [31:0] cyc_w = cyc_q + 32'd1;
   // window ends on the active (programmed or built-in) cycle count or early when far beyond the slow limit
   wire done_w = seen_q & ((edge_w & (cyc_w >= win_w)) | (dur_w > fl_w)); // RULE7
   wire far_out_w = (dur_w < fu_w) || (dur_w > fl_w); // RULE8
   wire near_in_w = (dur_w >= nu_w) && (dur_w <= nl_w);
   wire cand_w = far_out_w ? 1'b1 : (near_in_w ? 1'b0 : mp_fail_o); // RULE8

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_prev_q <= 1'b0;
         seen_q <= 1'b0;
         sync_q <= 1'b0;
         per_q <= 16'h0000;
         cls_q <= `DRM_CLS_8K;
         cyc_q <= 32'h00000000;
         dur_q <= 32'h00000000;
         have_q <= 1'b0;
         cand_q <= 1'b0;
         sp_fail_o <= 1'b1;
         mp_fail_o <= 1'b1;
         sp_evt_o <= 1'b0;
         mp_evt_o <= 1'b0;
      end else begin
         ref_prev_q <= ref_i;
         sp_evt_o <= 1'b0;
         mp_evt_o <= 1'b0;
         // single period check
         if (edge_w) begin
            per_q <= 16'h0000;
            seen_q <= 1'b1;
            if (seen_q) begin
               cls_q <= classify(per_w);
               sp_fail_o <= sp_bad_w; // RULE18 RULE3 RULE19
               sp_evt_o <= sp_bad_w & ~sp_fail_o;
            end
         end else begin
            per_q <= per_w;
            if (seen_q && per_w > lo_w) begin // RULE3
               sp_fail_o <= 1'b1;
               sp_evt_o <= ~sp_fail_o;
            end
         end
         // multi period check
         if (!seen_q) begin
            cyc_q <= 32'h00000000;
            dur_q <= 32'h00000000;
         end else if (sync_q && !edge_w && !(dur_w > fl_w)) begin
            // after an early end, next window starts on a reference edge
            dur_q <= dur_w;
         end else if (sync_q && edge_w) begin
            cyc_q <= 32'h00000000;
            dur_q <= 32'h00000000;
            sync_q <= 1'b0;
         end else if (done_w) begin
            cyc_q <= 32'h00000000;
            dur_q <= 32'h00000000;
            sync_q <= ~edge_w; // RULE7
            cand_q <= cand_w;
            have_q <= 1'b1;
            if (have_q && cand_w == cand_q) begin // RULE9 RULE19
               mp_fail_o <= cand_w;
               mp_evt_o <= cand_w ^ mp_fail_o;
            end
         end else begin
            dur_q <= dur_w;
            if (edge_w) cyc_q <= cyc_w;
         end
      end
   end
endmodule
`default_nettype wire

// ### test/drm_top_sva.sv
// port-level assertions for the reference monitor
`default_nettype none
module drm_top_chk (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [3:0] ref_clk_i,
   input wire logic [3:0] ref_fail_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // bus steps
   sequence wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid_o)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid_o)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped");
   unmapped_read_a: assert property (rd_take ##0 s_axi_araddr_i == 8'h80 |=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0)
      else $error("unmapped read not refused");
   wr_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while busy");
   rd_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken while busy");
   fail_reset_a: assert property ($fell(rst_i) |-> ref_fail_o == 4'hf)
      else $error("fail not set out of reset");
endmodule
bind drm_top drm_top_chk chk (.*);
`default_nettype wire

// ### test/drm_ref_src.sv
// four reference clock sources, stopped while period is zero
`default_nettype none
module drm_ref_src (
   input wire logic [11:0] per_ns_i [4],
   output wire logic [3:0] ref_clk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   for (genvar k = 0; k < 4; k++) begin : g_src
      logic r = 1'b0;
      assign ref_clk_o[k] = r;
      initial begin
         forever begin
            if (per_ns_i[k] == 12'h0) begin
               r = 1'b0;
               #10;
            end else begin
               #(per_ns_i[k] / 2.0);
               r = ~r;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test/dpll_reference_monitor_bench.sv
// self-checking bench for the reference monitor
`default_nettype none
module dpll_reference_monitor_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic c = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [3:0] refc, rfail;
   logic [11:0] per [4] = '{12'hc8, 12'h1f4, 12'h32, 12'hc8};
   logic [7:0] ra [15] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h64, 8'h68, 8'h6c,
      8'h70, 8'h74, 8'h78, 8'h7c};
   logic [31:0] rv [15] = '{32'h0, 32'h0, 32'h0, 32'h335c, 32'h2e4a, 32'h3880, 32'h1, 32'ha346, 32'h3b9a,
      32'h9de8, 32'h3b9a, 32'hf0b8, 32'h3b9a, 32'hf616, 32'h3b9a};
   logic [31:0] ml [4] = '{32'h4c, 32'h46, 32'h54, 32'h5a};
   int fails = 0, compares = 0;
   initial forever #2 c = ~c;
   drm_top uut (.core_clk_i(c), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ref_clk_i(refc),
      .ref_fail_o(rfail), .irq_o(irq));
   drm_ref_src src (.per_ns_i(per), .ref_clk_o(refc));
   // ==========================================
   // checking and bus tasks
   task automatic final_report;
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic hang;
      fails++;
      $display("MISMATCH %0t bus wait ran out", $time);
      final_report;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge c);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      repeat (200) begin
         @(negedge c);
         ta = awready;
         tw = wready;
         tb = bvalid;
         r = bresp;
         @(posedge c);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            chk({30'h0, r}, {30'h0, e});
            return;
         end
      end
      hang;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e);
      logic ta, tv;
      logic [1:0] r;
      @(posedge c);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (200) begin
         @(negedge c);
         ta = arready;
         tv = rvalid;
         r = rresp;
         v = rdata;
         @(posedge c);
         if (ta) arvalid <= 1'b0;
         if (tv) begin
            rready <= 1'b0;
            chk({30'h0, r}, {30'h0, e});
            return;
         end
      end
      hang;
   endtask
   task automatic wf(input logic [3:0] e, input int n);
      repeat (n) begin
         @(negedge c);
         if (rfail === e) break;
      end
      chk({28'h0, rfail}, {28'h0, e});
   endtask
   // ==========================================
   // scenarios
   initial begin
      repeat (12) @(posedge c);
      chk({28'h0, rfail}, 32'hf);
      rst <= 1'b0;
      for (int i = 0; i < 15; i++) begin
         rd(ra[i], d, 2'b00);
         chk(d, rv[i]);
      end
      rd(8'h80, d, 2'b10);
      chk(d, 32'h0);
      wr(8'h80, 32'h1, 2'b10);
      wr(8'h24, 32'hffff1234, 2'b00);
      rd(8'h24, d, 2'b00);
      chk(d, 32'h1234);
      wr(8'h00, 32'h4, 2'b00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h20 + 8'(4 * i), 32'h1e, 2'b00);
         wr(8'h30 + 8'(4 * i), 32'ha, 2'b00);
         wr(8'h40 + 8'(4 * i), 32'h4, 2'b00);
         wr(8'h50 + 8'(4 * i), 32'h0, 2'b00);
         wr(8'h60 + 8'(8 * i), ml[i], 2'b00);
         wr(8'h64 + 8'(8 * i), 32'h0, 2'b00);
      end
      wf(4'b0110, 5000);
      rd(8'h04, d, 2'b00);
      chk(d, 32'h66);
      wr(8'h08, 32'h22, 2'b00);
      wf(4'b0100, 50);
      per[0] <= 12'hd7;
      repeat (1500) @(negedge c);
      chk({28'h0, rfail}, 32'h4);
      per[0] <= 12'hf0;
      wf(4'b0101, 3000);
      per[0] <= 12'hd7;
      repeat (1500) @(negedge c);
      chk({28'h0, rfail}, 32'h5);
      per[0] <= 12'hc8;
      wf(4'b0100, 3000);
      wr(8'h10, 32'h1, 2'b00);
      rd(8'h0c, d, 2'b00);
      repeat (4) @(negedge c);
      chk({31'h0, irq}, 32'h0);
      per[0] <= 12'h0;
      wf(4'b0101, 200);
      chk({31'h0, irq}, 32'h1);
      rd(8'h0c, d, 2'b00);
      chk({31'h0, d[0]}, 32'h1);
      repeat (4) @(negedge c);
      chk({31'h0, irq}, 32'h0);
      per <= '{12'h288, 12'h1e8, 12'h32, 12'hc8};
      wr(8'h00, 32'h0, 2'b00);
      repeat (2000) @(posedge c);
      rd(8'h04, d, 2'b00);
      chk(d & 32'hf, 32'h0);
      final_report;
   end
endmodule
`default_nettype wire
